// [logic/fidc_top.sv]
// Forced-idle duty cycling control and residency counters
`default_nettype none
module fidc_top
  import fidc_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  // Capability strap pin
  input  wire logic                   cap_pin,
  // Register access port
  input  wire fidc_req_s              req,
  output var  fidc_rsp_s              rsp,
  // Sleep state from power control, same clock
  input  wire logic                   timestamp_tick,
  input  wire logic [NUM_CORES*CST_W-1:0] core_cstate,
  input  wire logic [CST_W-1:0]       pkg_cstate,
  // Thread controls
  output logic [NUM_THREADS-1:0]      force_idle,
  output logic [NUM_THREADS-1:0]      ref_count_run,
  output logic [NUM_THREADS-1:0]      act_count_run
);

  // ********************************************************************
  // Helpers
  // ********************************************************************
  // Core that owns a thread: the upper bits of the thread number
  function automatic logic [CORE_W-1:0] core_of(
      input logic [THR_W-1:0] t);
    core_of = t[THR_W-1:THR_W-CORE_W];
  endfunction : core_of

  // Package state against the deep select code; reserved codes match
  // nothing, so the deep count stands still rather than count garbage
  function automatic logic deep_hit(input logic [2:0]       sel,
                                    input logic [CST_W-1:0] st);
    case (sel)
      SEL_C2:   deep_hit = (st == CST_TWO);
      SEL_C3UP: deep_hit = (st >= CST_THREE);
      SEL_C6UP: deep_hit = (st >= CST_SIX);
      SEL_C7UP: deep_hit = (st >= CST_SEVEN);
      default:  deep_hit = 1'b0;
    endcase
  endfunction : deep_hit

  // ********************************************************************
  // State
  // ********************************************************************
  // Strap synchroniser, control bits and enable propagation
  logic                   cap_meta;
  logic                   cap_sync;
  logic                   package_duty_enable;
  logic                   enable_arrived;
  logic [PROP_W-1:0]      prop_cnt;
  logic [NUM_THREADS-1:0] thread_allow_bit;
  logic [2:0]             deep_state_select;
  // Visible totals and the ticks still gathering behind them
  logic [DATA_W-1:0]      thr_total [NUM_THREADS];
  logic [DATA_W-1:0]      thr_pend  [NUM_THREADS];
  logic [DATA_W-1:0]      core_idle_cycles [NUM_CORES];
  logic [DATA_W-1:0]      core_pend [NUM_CORES];
  logic [DATA_W-1:0]      shallow_total;
  logic [DATA_W-1:0]      shallow_pend;
  logic [DATA_W-1:0]      package_deep_cycles;
  logic [DATA_W-1:0]      deep_pend;
  // Last cycle's idle conditions, to spot an exit
  logic [NUM_CORES-1:0]   core_deep_q;
  logic                   pkg_shallow_q;
  logic                   pkg_deep_q;

  // ********************************************************************
  // Decode
  // ********************************************************************
  // Address hits and access checks
  logic                   hit_ctl;
  logic                   hit_allow;
  logic                   hit_stall;
  logic                   hit_core;
  logic                   hit_shallow;
  logic                   hit_deep;
  logic                   hit_cfg;
  logic                   any_hit;
  logic                   rsvd_bad;
  logic                   acc_fault;
  logic                   wr_ok;
  // Residency conditions
  logic [NUM_CORES-1:0]   core_forced;
  logic [NUM_CORES-1:0]   core_deep_now;
  logic                   any_forced;
  logic                   pkg_shallow_now;
  logic                   pkg_deep_now;

  // One hit per mapped address; anything else faults
  assign hit_ctl     = req.addr == ADDR_PKG_CTL;
  assign hit_allow   = req.addr == ADDR_ALLOW;
  assign hit_stall   = req.addr == ADDR_THR_STALL;
  assign hit_core    = req.addr == ADDR_CORE_RES;
  assign hit_shallow = req.addr == ADDR_SHALLOW;
  assign hit_deep    = req.addr == ADDR_DEEP;
  assign hit_cfg     = req.addr == ADDR_CONFIG;
  assign any_hit     = hit_ctl | hit_allow | hit_stall | hit_core |
                       hit_shallow | hit_deep | hit_cfg;

  // Nonzero reserved bits or a write to a counter are refused
  assign rsvd_bad = req.write &
                    (((hit_ctl | hit_allow) &
                      (|(req.wdata & ONE_BIT_RSVD))) |
                     (hit_cfg & (|(req.wdata & CONFIG_RSVD))) |
                     hit_stall | hit_core | hit_shallow | hit_deep);

  // Every register is absent without the capability
  // A refused access changes no state and answers with a fault
  assign acc_fault = ~any_hit | rsvd_bad | ~cap_sync;
  assign wr_ok     = req.valid & req.write & ~acc_fault;

  // Idle conditions seen this cycle
  always_comb begin
    for (int c = 0; c < NUM_CORES; c++) begin
      core_forced[c]   = |force_idle[c*THR_PER_CORE +: THR_PER_CORE];
      core_deep_now[c] = (core_cstate[c*CST_W +: CST_W] >= CST_THREE) &
                         core_forced[c];
    end
  end

  assign any_forced      = |core_forced;
  assign pkg_shallow_now = (pkg_cstate == CST_TWO) & any_forced;
  assign pkg_deep_now    = deep_hit(deep_state_select, pkg_cstate) &
                           any_forced;

  // ********************************************************************
  // Capability strap synchroniser
  // ********************************************************************
  // Two flops on the strap pin; only cap_sync is read by the logic.
  // Until it settles after reset every access faults
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cap_meta <= 1'b0;
      cap_sync <= 1'b0;
    end else begin
      cap_meta <= cap_pin;
      cap_sync <= cap_meta;
    end
  end

  // ********************************************************************
  // Control registers
  // ********************************************************************
  // Package enable, written from any thread
  // Repeated writes of the same value change nothing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      package_duty_enable <= ENABLE_RST;
    end else if (wr_ok & hit_ctl) begin
      package_duty_enable <= req.wdata[ENABLE_BIT];
    end
  end

  // Allow bits, one per thread, selected by the issuing thread
  // Only the issuing thread's own bit is written
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      thread_allow_bit <= {NUM_THREADS{ALLOW_RST}};
    end else if (wr_ok & hit_allow) begin
      thread_allow_bit[req.thread] <= req.wdata[ALLOW_BIT];
    end
  end

  // Deep counter select
  // Reserved codes are stored as written and count nothing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      deep_state_select <= SELECT_RST;
    end else if (wr_ok & hit_cfg) begin
      deep_state_select <= req.wdata[SELECT_LSB +: SELECT_W];
    end
  end

  // ********************************************************************
  // Enable propagation
  // ********************************************************************
  // The package enable reaches the threads only after a long delay
  // An enable that returns before it arrives restarts the wait and
  // leaves force_idle as it was
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prop_cnt       <= '0;
      enable_arrived <= ENABLE_RST;
    end else if (enable_arrived == package_duty_enable) begin
      prop_cnt <= '0;
    end else if (prop_cnt == PROP_W'(PROP_CYC - 1)) begin
      prop_cnt       <= '0;
      enable_arrived <= package_duty_enable;
    end else begin
      prop_cnt <= prop_cnt + 1'b1;
    end
  end

  // ********************************************************************
  // Forced idle
  // ********************************************************************
  // An arriving rise forces the allowed threads, an arriving fall
  // wakes them all; clearing the allow bit of a forced thread wakes
  // the whole package so no thread idles against its will
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      force_idle <= '0;
    end else if (enable_arrived & ~package_duty_enable &
                 (prop_cnt == PROP_W'(PROP_CYC - 1))) begin
      force_idle <= '0;
    end else if (~enable_arrived & package_duty_enable &
                 (prop_cnt == PROP_W'(PROP_CYC - 1))) begin
      force_idle <= thread_allow_bit;
    end else if (|(force_idle & ~thread_allow_bit)) begin
      force_idle <= '0;
    end
  end

  // Performance counter gating per thread
  // The reference count runs through forced idle, the actual one stops
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ref_count_run <= '0;
      act_count_run <= '0;
    end else begin
      ref_count_run <= {NUM_THREADS{timestamp_tick}};
      act_count_run <= {NUM_THREADS{timestamp_tick}} & ~force_idle;
    end
  end

  // ********************************************************************
  // Thread stall counters
  // ********************************************************************
  // Ticks gather while forced and fold in on exit
  // Folding only on exit keeps software from reading a half period
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        thr_pend[t]  <= '0;
        thr_total[t] <= '0;
      end
    end else begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        if (force_idle[t]) begin
          thr_pend[t] <= thr_pend[t] + DATA_W'(timestamp_tick);
        end else if (thr_pend[t] != '0) begin
          thr_total[t] <= thr_total[t] + thr_pend[t];
          thr_pend[t]  <= '0;
        end
      end
    end
  end

  // ********************************************************************
  // Core residency counters
  // ********************************************************************
  // Ticks gather while the core sleeps deep with a forced thread and
  // fold into the visible count the cycle after the condition drops
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      core_deep_q <= '0;
      for (int c = 0; c < NUM_CORES; c++) begin
        core_pend[c]        <= '0;
        core_idle_cycles[c] <= '0;
      end
    end else begin
      core_deep_q <= core_deep_now;
      for (int c = 0; c < NUM_CORES; c++) begin
        if (core_deep_now[c]) begin
          core_pend[c] <= core_pend[c] + DATA_W'(timestamp_tick);
        end else if (core_deep_q[c]) begin
          core_idle_cycles[c] <= core_idle_cycles[c] + core_pend[c];
          core_pend[c]        <= '0;
        end
      end
    end
  end

  // ********************************************************************
  // Package residency counters
  // ********************************************************************
  // Shallow counter
  // Gathers like the core counters and folds the cycle after exit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pkg_shallow_q <= 1'b0;
      shallow_pend  <= '0;
      shallow_total <= '0;
    end else begin
      pkg_shallow_q <= pkg_shallow_now;
      if (pkg_shallow_now) begin
        shallow_pend <= shallow_pend + DATA_W'(timestamp_tick);
      end else if (pkg_shallow_q) begin
        shallow_total <= shallow_total + shallow_pend;
        shallow_pend  <= '0;
      end
    end
  end

  // Deep counter on the selected state
  // A select change takes effect on the next cycle's condition
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pkg_deep_q          <= 1'b0;
      deep_pend           <= '0;
      package_deep_cycles <= '0;
    end else begin
      pkg_deep_q <= pkg_deep_now;
      if (pkg_deep_now) begin
        deep_pend <= deep_pend + DATA_W'(timestamp_tick);
      end else if (pkg_deep_q) begin
        package_deep_cycles <= package_deep_cycles + deep_pend;
        deep_pend           <= '0;
      end
    end
  end

  // ********************************************************************
  // Register answers
  // ********************************************************************
  // One cycle after a request: data, or a protection fault
  // Thread registers are indexed by the thread that issued the request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rsp <= '0;
    end else begin
      rsp.ack   <= req.valid;
      rsp.fault <= req.valid & acc_fault;
      rsp.rdata <= '0;
      if (req.valid & ~req.write & ~acc_fault) begin
        case (1'b1)
          hit_ctl:     rsp.rdata <= DATA_W'(package_duty_enable);
          hit_allow:   rsp.rdata <= DATA_W'(thread_allow_bit[req.thread]);
          hit_stall:   rsp.rdata <= thr_total[req.thread];
          hit_core:    rsp.rdata <= core_idle_cycles[core_of(req.thread)];
          hit_shallow: rsp.rdata <= shallow_total;
          hit_deep:    rsp.rdata <= package_deep_cycles;
          hit_cfg:     rsp.rdata <= DATA_W'(deep_state_select);
          default:     rsp.rdata <= '0;
        endcase
      end
    end
  end

endmodule : fidc_top
`default_nettype wire

// [common/fidc_pkg.sv]
// Constants, register map and carriers for the forced-idle duty block
`default_nettype none
package fidc_pkg;

  // ********************************************************************
  // Sizes
  // ********************************************************************
  localparam int NUM_THREADS  = 4;
  localparam int THR_PER_CORE = 2;
  localparam int NUM_CORES    = NUM_THREADS / THR_PER_CORE;
  localparam int THR_W        = 2;
  localparam int CORE_W       = 1;
  localparam int ADDR_W       = 12;
  localparam int DATA_W       = 64;
  localparam int CST_W        = 3;

  // ********************************************************************
  // Register addresses
  // ********************************************************************
  localparam logic [ADDR_W-1:0] ADDR_PKG_CTL   = 12'hdb0;
  localparam logic [ADDR_W-1:0] ADDR_ALLOW     = 12'hdb1;
  localparam logic [ADDR_W-1:0] ADDR_THR_STALL = 12'hdb2;
  localparam logic [ADDR_W-1:0] ADDR_CORE_RES  = 12'h653;
  localparam logic [ADDR_W-1:0] ADDR_SHALLOW   = 12'h655;
  localparam logic [ADDR_W-1:0] ADDR_DEEP      = 12'h656;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG    = 12'h652;

  // ********************************************************************
  // Fields and reset values
  // ********************************************************************
  localparam int ENABLE_BIT  = 0;
  localparam int ALLOW_BIT   = 0;
  localparam int SELECT_LSB  = 0;
  localparam int SELECT_W    = 3;
  localparam logic       ENABLE_RST = 1'b0;
  localparam logic       ALLOW_RST  = 1'b1;
  localparam logic [2:0] SELECT_RST = 3'h0;
  localparam logic [DATA_W-1:0] ONE_BIT_RSVD = 64'hffff_ffff_ffff_fffe;
  localparam logic [DATA_W-1:0] CONFIG_RSVD  = 64'hffff_ffff_ffff_fff8;

  // Deep select encodings and sleep state codes
  localparam logic [2:0] SEL_OFF   = 3'h0;
  localparam logic [2:0] SEL_C2    = 3'h1;
  localparam logic [2:0] SEL_C3UP  = 3'h2;
  localparam logic [2:0] SEL_C6UP  = 3'h3;
  localparam logic [2:0] SEL_C7UP  = 3'h4;
  localparam logic [CST_W-1:0] CST_TWO   = 3'h2;
  localparam logic [CST_W-1:0] CST_THREE = 3'h3;
  localparam logic [CST_W-1:0] CST_SIX   = 3'h6;
  localparam logic [CST_W-1:0] CST_SEVEN = 3'h7;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROP_NS       = 100;
  localparam int PROP_CYC      = (PROP_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                 PROP_NS / CLK_PERIOD_NS;
  localparam int PROP_W        = 5;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [THR_W-1:0]  thread;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fidc_req_s;

  typedef struct packed {
    logic              ack;
    logic              fault;
    logic [DATA_W-1:0] rdata;
  } fidc_rsp_s;

endpackage : fidc_pkg
`default_nettype wire

// [verification/fidc_checker.sv]
// Port assertions for the forced-idle duty block
`default_nettype none
module fidc_checker
  import fidc_pkg::*;
(
  // Clock and reset
  input wire logic                       ref_clk,
  input wire logic                       sys_rst,
  // Inputs
  input wire logic                       cap_pin,
  input wire fidc_req_s                  req,
  input wire logic                       timestamp_tick,
  input wire logic [NUM_CORES*CST_W-1:0] core_cstate,
  input wire logic [CST_W-1:0]           pkg_cstate,
  // Outputs
  input wire fidc_rsp_s                  rsp,
  input wire logic [NUM_THREADS-1:0]     force_idle,
  input wire logic [NUM_THREADS-1:0]     ref_count_run,
  input wire logic [NUM_THREADS-1:0]     act_count_run
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // Decoded enable and allow writes
  logic wr_ctl;
  logic wr_on;
  logic wr_off;
  logic wr_blk;
  assign wr_ctl = req.valid && req.write && req.addr == ADDR_PKG_CTL;
  assign wr_on  = wr_ctl && req.wdata == 64'h1;
  assign wr_off = wr_ctl && req.wdata == 64'h0;
  assign wr_blk = req.valid && req.write && req.addr == ADDR_ALLOW &&
                  req.wdata == 64'h0 && force_idle[req.thread];
  // ****
  // Assertions
  // ****
  a_ack_follows:
    assert property (req.valid |=> rsp.ack)
    else $error("request not acknowledged");
  a_ack_quiet:
    assert property (!req.valid |=> !rsp.ack && !rsp.fault)
    else $error("ack without request");
  a_ref_runs:
    assert property (!$past(sys_rst) |->
      ref_count_run == {NUM_THREADS{$past(timestamp_tick)}})
    else $error("reference run does not follow tick");
  a_act_stops:
    assert property (!$past(sys_rst) |-> act_count_run ==
      ({NUM_THREADS{$past(timestamp_tick)}} & ~$past(force_idle)))
    else $error("actual run not masked by forced idle");
  a_rise_delay:
    assert property ($rose(|force_idle) |-> $past(wr_on, 13))
    else $error("forced idle without enable 13 cycles before");
  a_fall_delay:
    assert property ((wr_off && |force_idle) ##1 !rsp.fault |->
      ##12 force_idle == '0)
    else $error("forced idle not released after disable");
  a_block_wakes:
    assert property (wr_blk ##1 !rsp.fault |-> ##[0:2] force_idle == '0)
    else $error("blocking a forced thread did not wake all");
  a_count_ro:
    assert property (req.valid && req.write &&
      req.addr == ADDR_THR_STALL |=> rsp.fault)
    else $error("write to stall count not refused");
  a_no_cap:
    assert property (req.valid && !cap_pin && !$past(cap_pin) &&
      !$past(cap_pin, 2) && !$past(cap_pin, 3) |=> rsp.fault)
    else $error("access without capability not refused");
endmodule : fidc_checker

bind fidc_top fidc_checker u_checker (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cap_pin(cap_pin), .req(req),
  .timestamp_tick(timestamp_tick), .core_cstate(core_cstate),
  .pkg_cstate(pkg_cstate), .rsp(rsp), .force_idle(force_idle),
  .ref_count_run(ref_count_run), .act_count_run(act_count_run)
);
`default_nettype wire

// [verification/fidc_top_test.sv]
// Self-checking bench for the forced-idle duty block
`default_nettype none
module fidc_top_test
  import fidc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Signals and expected counts
  // ****
  logic                       ref_clk = 1'b0;
  logic                       sys_rst;
  logic                       cap_pin;
  fidc_req_s                  req;
  fidc_rsp_s                  rsp;
  logic                       timestamp_tick;
  logic [NUM_CORES*CST_W-1:0] core_cstate;
  logic [CST_W-1:0]           pkg_cstate;
  logic [NUM_THREADS-1:0]     force_idle;
  logic [NUM_THREADS-1:0]     alw;
  logic [2:0]                 cur_sel = 3'h0;
  logic                       run_rand = 1'b0;
  logic [DATA_W-1:0]          exp_thr [NUM_THREADS];
  logic [DATA_W-1:0]          exp_core [NUM_CORES];
  logic [DATA_W-1:0]          exp_sh;
  logic [DATA_W-1:0]          exp_dp;
  int                         err_count = 0;
  int                         cmp_count = 0;
  int                         cyc = 0;

  fidc_top DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cap_pin(cap_pin), .req(req),
    .rsp(rsp), .timestamp_tick(timestamp_tick), .core_cstate(core_cstate),
    .pkg_cstate(pkg_cstate), .force_idle(force_idle),
    .ref_count_run(), .act_count_run()
  );

  // Clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  // Deep count match for a select code
  function automatic logic deep_hit(logic [2:0] sel, logic [2:0] st);
    case (sel)
      SEL_C2:   return st == CST_TWO;
      SEL_C3UP: return st >= CST_THREE;
      SEL_C6UP: return st >= CST_SIX;
      SEL_C7UP: return st >= CST_SEVEN;
      default:  return 1'b0;
    endcase
  endfunction : deep_hit

  // Random ticks and sleep states for the next rising edge, drawn at
  // the falling edge, then the totals that edge should add; force_idle
  // has settled since the last rising edge
  always @(negedge ref_clk) begin
    timestamp_tick = 1'($urandom_range(0, 1));
    core_cstate    = run_rand ? (NUM_CORES*CST_W)'($urandom) : '0;
    pkg_cstate     = run_rand ? 3'($urandom) : '0;
    if (sys_rst) begin
      exp_thr  = '{default: '0};
      exp_core = '{default: '0};
      exp_sh   = '0;
      exp_dp   = '0;
    end else if (timestamp_tick) begin
      for (int t = 0; t < NUM_THREADS; t++) begin
        exp_thr[t] += 64'(force_idle[t]);
      end
      for (int c = 0; c < NUM_CORES; c++) begin
        exp_core[c] += 64'(core_cstate[c*CST_W +: CST_W] >= CST_THREE &&
          |force_idle[c*THR_PER_CORE +: THR_PER_CORE]);
      end
      exp_sh += 64'(pkg_cstate == CST_TWO && |force_idle);
      exp_dp += 64'(deep_hit(cur_sel, pkg_cstate) && |force_idle);
    end
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end

  // ****
  // Tasks
  // ****
  task automatic check(string n, logic [63:0] seen, logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  // One access taken at the next rising edge; valid stays up after
  task automatic xfer(logic [1:0] thr, logic wr, logic [11:0] a,
                      logic [63:0] d, logic ef, logic cd, logic [63:0] ed);
    req = '{1'b1, wr, thr, a, d};
    @(posedge ref_clk);
    @(negedge ref_clk);
    check("ack", 64'(rsp.ack), 64'h1);
    check("fault", 64'(rsp.fault), 64'(ef));
    if (cd) check("rdata", rsp.rdata, ed);
  endtask : xfer

  task automatic wreg(logic [1:0] thr, logic [11:0] a, logic [63:0] d,
                      logic ef);
    xfer(thr, 1'b1, a, d, ef, 1'b0, '0);
  endtask : wreg

  task automatic rreg(logic [1:0] thr, logic [11:0] a, logic ef,
                      logic [63:0] ed);
    xfer(thr, 1'b0, a, '0, ef, !ef, ed);
  endtask : rreg

  task automatic idle(int n);
    req.valid = 1'b0;
    repeat (n) @(negedge ref_clk);
  endtask : idle

  task automatic finish_test();
    $display("TB: %0d compared, %0d mismatched", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(23353));
    sys_rst     = 1'b1;
    cap_pin     = 1'b1;
    req         = '0;
    timestamp_tick = 1'b0;
    core_cstate = '0;
    pkg_cstate  = '0;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    // Reset values and an unmapped address
    for (int t = 0; t < NUM_THREADS; t++) begin
      rreg(2'(t), ADDR_ALLOW, 1'b0, 64'h1);
      rreg(2'(t), ADDR_THR_STALL, 1'b0, '0);
    end
    rreg(2'(0), ADDR_PKG_CTL, 1'b0, '0);
    rreg(2'(2), ADDR_CORE_RES, 1'b0, '0);
    rreg(2'(1), ADDR_SHALLOW, 1'b0, '0);
    rreg(2'(3), ADDR_DEEP, 1'b0, '0);
    rreg(2'(0), ADDR_CONFIG, 1'b0, '0);
    rreg(2'(0), 12'h000, 1'b1, '0);
    idle(1);
    $display("TB: reset values done");
    // Select codes 0 to 4, then refused writes back to back
    for (int s = 0; s < 5; s++) begin
      wreg(2'(s % 4), ADDR_CONFIG, 64'(s), 1'b0);
      rreg(2'(0), ADDR_CONFIG, 1'b0, 64'(s));
    end
    wreg(2'(0), ADDR_CONFIG, 64'hc, 1'b1);
    rreg(2'(0), ADDR_CONFIG, 1'b0, 64'h4);
    wreg(2'(1), ADDR_PKG_CTL, 64'h2, 1'b1);
    wreg(2'(2), ADDR_THR_STALL, 64'h5, 1'b1);
    wreg(2'(3), ADDR_DEEP, 64'h5, 1'b1);
    idle(1);
    $display("TB: config and refusals done");
    // Duty rounds with random allow bits and sleep states
    for (int s = 1; s < 5; s++) begin
      alw = 4'($urandom);
      wreg(2'(0), ADDR_CONFIG, 64'(s), 1'b0);
      cur_sel  = 3'(s);
      run_rand = 1'b1;
      wreg(2'(s % 4), ADDR_PKG_CTL, 64'h1, 1'b0);
      for (int t = 0; t < NUM_THREADS; t++) begin
        wreg(2'(t), ADDR_ALLOW, 64'(alw[t]), 1'b0);
      end
      idle(14);
      check("force_idle", 64'(force_idle), 64'(alw));
      for (int t = 0; t < NUM_THREADS; t++) begin
        if (!alw[t]) wreg(2'(t), ADDR_ALLOW, 64'h1, 1'b0);
      end
      xfer(2'(0), 1'b0, ADDR_THR_STALL, '0, 1'b0, 1'b0, '0);
      idle(30);
      check("force_idle", 64'(force_idle), 64'(alw));
      wreg(2'(3 - s % 4), ADDR_PKG_CTL, 64'h0, 1'b0);
      idle(14);
      check("force_idle", 64'(force_idle), '0);
      run_rand = 1'b0;
      idle(4);
      for (int t = 0; t < NUM_THREADS; t++) begin
        rreg(2'(t), ADDR_THR_STALL, 1'b0, exp_thr[t]);
      end
      rreg(2'(0), ADDR_CORE_RES, 1'b0, exp_core[0]);
      rreg(2'(2), ADDR_CORE_RES, 1'b0, exp_core[1]);
      rreg(2'(1), ADDR_SHALLOW, 1'b0, exp_sh);
      rreg(2'(3), ADDR_DEEP, 1'b0, exp_dp);
      idle(1);
    end
    $display("TB: duty rounds done");
    // Blocking one forced thread wakes them all
    for (int t = 0; t < NUM_THREADS; t++) begin
      wreg(2'(t), ADDR_ALLOW, 64'h1, 1'b0);
    end
    wreg(2'(2), ADDR_PKG_CTL, 64'h1, 1'b0);
    idle(14);
    check("force_idle", 64'(force_idle), 64'hf);
    wreg(2'(1), ADDR_ALLOW, 64'h0, 1'b0);
    idle(3);
    check("force_idle", 64'(force_idle), '0);
    wreg(2'(0), ADDR_PKG_CTL, 64'h0, 1'b0);
    idle(14);
    $display("TB: blocking done");
    // Capability strap low refuses everything
    cap_pin = 1'b0;
    idle(4);
    rreg(2'(0), ADDR_THR_STALL, 1'b1, '0);
    rreg(2'(2), ADDR_CORE_RES, 1'b1, '0);
    wreg(2'(0), ADDR_PKG_CTL, 64'h1, 1'b1);
    idle(1);
    cap_pin = 1'b1;
    idle(4);
    rreg(2'(0), ADDR_PKG_CTL, 1'b0, '0);
    rreg(2'(1), ADDR_THR_STALL, 1'b0, exp_thr[1]);
    idle(1);
    $display("TB: capability done");
    finish_test();
  end
endmodule : fidc_top_test
`default_nettype wire
